// ===== lcd_segment_driver.sv
/*
  lcd_segment_driver: clock selection and prescale, supply control,
  low-power gating, backplane phase sequencing, blink timing and
  frontplane enable gating of a segment lcd driver.
  assumes: register port and low-power mode inputs synchronous to
  i_clk_sys; external reference is a slow level sampled on i_clk_sys;
  analog stages act on the supply and bias control outputs.
*/
// Summary of operation
// R1: bus clock if source bit 1, else external
// R2: prescale by sixteen and clock adjust field
// R3: pump enable bit turns charge pump on
// R4: pump doubler at 0, tripler at 1; the code drives doubler when supply select is 01
// R5: bias stage buffered at 0, unbuffered at 1
// R6: supply 01 powers from core, third bias
// R7: display keeps running in wait if enabled
// R8: display stops in deep_low_power_state if disabled
// R9: duty 10 sequences three backplanes
// R10: frame clock select divides base frequency
// R11: blink mode selects segments or all
// R12: blink rate field sets blink period
// R13: one enable bit per frontplane pin
// R14: disabled frontplanes released to other functions
`timescale 1ns/100ps
module lcd_segment_driver
  import lcd_pkg::*;
#(
  parameter int NUM_FP = 41,
  parameter int BLINK_UNIT = LCD_BLINK_UNIT_FRAMES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [LCD_ADDR_W-1:0] i_addr,
  input wire logic [LCD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [LCD_DATA_W-1:0] o_rdata,
  input wire logic i_ext_ref,
  input wire logic i_wait_mode,
  input wire logic i_deep_low_power_state_mode,
  output logic o_clk_from_bus,
  output logic o_base_tick,
  output logic o_pump_on,
  output logic o_pump_triple,
  output logic o_high_drive,
  output logic [1:0] o_pump_clock_adjust,
  output logic o_buffer_bypass,
  output logic o_core_supply,
  output logic o_bias3_from_core,
  output logic o_low_power_wave,
  output logic o_display_on,
  output logic [3:0] o_bp_active,
  output logic o_wave_polarity,
  output logic [NUM_FP-1:0] o_fp_drive,
  output logic [NUM_FP-1:0] o_fp_lcd_owned,
  output logic o_blink_blank_sel
);
  lcd_cfg_t cfg;
  logic [NUM_FP-1:0] fp_en;
  logic ext_q;
  logic ext_edge;
  logic src_tick;
  logic pre_tick;
  logic base_tick;
  logic phase_tick;
  logic run;
  logic [3:0] pre_limit;
  logic [7:0] frame_limit;
  logic [1:0] phase_q;
  logic [1:0] last_phase;
  logic frame_end;
  logic polarity_q;
  logic [LCD_BLINK_CNT_W-1:0] blink_cnt_q;
  logic [LCD_BLINK_CNT_W-1:0] blink_limit;
  logic blink_off_q;
  logic blank_all;
  logic display_on_q;
  logic [3:0] bp_q;
  logic [NUM_FP-1:0] fp_drive_q;
  logic pump_on_q;
  logic pump_triple_q;
  logic high_drive_q;
  logic [1:0] pump_adj_q;
  logic bypass_q;
  logic core_q;

  lcd_regs #(
    .NUM_FP(NUM_FP)
  ) u_regs (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_cfg(cfg),
    .o_fp_en(fp_en)
  );

  // low-power gating: the whole divider chain halts with the display
  always_comb begin
    run = 1'b1;
    if (i_wait_mode && cfg.cr1.wait_mode_disable) begin
      run = 1'b0;
    end
    if (i_deep_low_power_state_mode && cfg.cr1.deep_low_power_state_mode_disable) begin
      run = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      display_on_q <= 1'b0;
    end else begin
      display_on_q <= run; // R7 R8
    end
  end

  // external reference is sampled, so it must stay well below the bus rate
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= i_ext_ref;
    end
  end

  assign ext_edge = i_ext_ref && !ext_q;
  assign src_tick = (cfg.clk.clock_source == LCD_SRC_BUS) ? 1'b1 : ext_edge; // R1
  assign pre_limit = cfg.clk.prescale_by_sixteen ? LCD_PRESCALE_BY_SIXTEEN_LIMIT : 4'h0; // R2

  lcd_tick_div #(
    .W(4)
  ) u_pre (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_run(run),
    .i_tick(src_tick),
    .i_limit(pre_limit),
    .o_tick(pre_tick)
  );

  lcd_tick_div #(
    .W(6)
  ) u_adj (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_run(run),
    .i_tick(pre_tick),
    .i_limit(cfg.clk.clock_adjust_field), // R2
    .o_tick(base_tick)
  );

  // frame select is a power-of-two divide of the base frequency
  assign frame_limit = 8'((9'h001 << cfg.cr0.frame_clock_select) - 9'h001); // R10

  lcd_tick_div #(
    .W(8)
  ) u_frame (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_run(run),
    .i_tick(base_tick),
    .i_limit(frame_limit),
    .o_tick(phase_tick)
  );

  // one backplane phase per tick; duty code plus one gives the phase count
  assign last_phase = cfg.cr0.duty; // R9
  assign frame_end = phase_tick && (phase_q >= last_phase);

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      phase_q <= 2'h0;
    end else if (phase_tick) begin
      if (phase_q >= last_phase) begin
        phase_q <= 2'h0; // R9
      end else begin
        phase_q <= phase_q + 2'h1;
      end
    end
  end

  // polarity flips each frame to keep the glass free of dc
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      polarity_q <= 1'b0;
    end else if (frame_end) begin
      polarity_q <= !polarity_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      bp_q <= 4'h0;
    end else if (!run) begin
      bp_q <= 4'h0;
    end else begin
      bp_q <= 4'h1 << phase_q;
    end
  end

  // blink half period: unit frames times two to the rate
  assign blink_limit = LCD_BLINK_CNT_W'((BLINK_UNIT << cfg.blk.blink_rate) - 1); // R12

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      blink_cnt_q <= '0;
      blink_off_q <= 1'b0;
    end else if (!cfg.blk.blink_enable) begin
      blink_cnt_q <= '0;
      blink_off_q <= 1'b0;
    end else if (frame_end) begin
      if (blink_cnt_q >= blink_limit) begin
        blink_cnt_q <= '0;
        blink_off_q <= !blink_off_q; // R12
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end

  assign blank_all = blink_off_q && cfg.blk.blink_mode; // R11

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_blink_blank_sel <= 1'b0;
    end else begin
      o_blink_blank_sel <= blink_off_q && !cfg.blk.blink_mode; // R11
    end
  end

  for (genvar g = 0; g < NUM_FP; g++) begin : g_fp
    always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
        fp_drive_q[g] <= 1'b0;
      end else begin
        fp_drive_q[g] <= fp_en[g] && run && !blank_all; // R13 R11
      end
    end
  end

  // supply and bias controls registered so the analog side sees clean levels
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      pump_on_q <= 1'b0;
      pump_triple_q <= 1'b0;
      high_drive_q <= 1'b0;
      pump_adj_q <= 2'h0;
      bypass_q <= 1'b0;
      core_q <= 1'b0;
    end else begin
      pump_on_q <= cfg.sup.charge_pump_enable; // R3
      pump_triple_q <= (cfg.sup.pump_multiplier_select == LCD_PUMP_TRIPLER)
                       && (cfg.sup.supply_select != LCD_SUPPLY_CORE); // R4
      high_drive_q <= cfg.sup.high_drive_buffer;
      pump_adj_q <= cfg.sup.pump_clock_adjust;
      bypass_q <= cfg.sup.buffer_bypass; // R5
      core_q <= cfg.sup.supply_select == LCD_SUPPLY_CORE; // R6
    end
  end

  assign o_clk_from_bus = cfg.clk.clock_source;
  assign o_base_tick = base_tick;
  assign o_pump_on = pump_on_q;
  assign o_pump_triple = pump_triple_q;
  assign o_high_drive = high_drive_q;
  assign o_pump_clock_adjust = pump_adj_q;
  assign o_buffer_bypass = bypass_q;
  assign o_core_supply = core_q;
  assign o_bias3_from_core = core_q; // R6
  assign o_low_power_wave = cfg.cr0.low_power_waveform;
  assign o_display_on = display_on_q;
  assign o_bp_active = bp_q;
  assign o_wave_polarity = polarity_q;
  assign o_fp_drive = fp_drive_q;
  assign o_fp_lcd_owned = fp_en; // R14

  a_ext_source_only: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R1
    (!cfg.clk.clock_source && !ext_edge) |-> !src_tick)
    else $error("lcd clock ticked without external reference edge");

  a_prescale_chain: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R2
    base_tick |-> $past(pre_tick))
    else $error("base tick without prescaler tick");

  a_pump_follows: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R3
    $rose(cfg.sup.charge_pump_enable) |=> o_pump_on)
    else $error("charge pump not on after enable");

  a_pump_core_off: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R4
    o_pump_triple |-> !o_core_supply)
    else $error("tripler active on core supply");

  a_bypass_mode: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R5
    ##1 o_buffer_bypass == $past(cfg.sup.buffer_bypass))
    else $error("buffer bypass output mismatch");

  a_core_bias: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R6
    (cfg.sup.supply_select == LCD_SUPPLY_CORE) |=> (o_core_supply && o_bias3_from_core))
    else $error("core supply not selected");

  a_wait_running: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R7
    (i_wait_mode && !cfg.cr1.wait_mode_disable && !i_deep_low_power_state_mode) |=> o_display_on)
    else $error("display stopped in wait mode");

  a_deep_low_power_state_blank: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R8
    (i_deep_low_power_state_mode && cfg.cr1.deep_low_power_state_mode_disable) |=> (!o_display_on && o_fp_drive == '0))
    else $error("display still driven in deep_low_power_state");

  a_third_duty: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R9
    (phase_tick && cfg.cr0.duty == LCD_DUTY_THIRD && phase_q == 2'h2) |=> phase_q == 2'h0)
    else $error("third duty did not wrap after three phases");

  a_frame_spacing: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R10
    (phase_tick && cfg.cr0.frame_clock_select != 3'h0 && $stable(cfg.cr0))
      |=> !phase_tick)
    else $error("frame tick too close to previous");

  a_blink_all: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R11
    (blink_off_q && cfg.blk.blink_mode) |=> (o_fp_drive == '0 && !o_blink_blank_sel))
    else $error("blink all left segments driven");

  a_blink_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R12
    (cfg.blk.blink_enable && $changed(blink_off_q)) |-> $past(frame_end))
    else $error("blink toggled off frame boundary");

  a_fp_enable_gate: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R13
    ##1 (o_fp_drive & ~$past(fp_en)) == '0)
    else $error("disabled frontplane driven");
endmodule

// ===== lcd_pkg.sv
/*
  lcd_pkg: register indices, field positions, reset values, encodings and
  timing constants of the segment lcd driver configuration block.
  assumes: an 8-bit plain register port; every register is one index.
*/
package lcd_pkg;

  localparam int LCD_ADDR_W = 4;
  localparam int LCD_DATA_W = 8;

  // register indices
  localparam logic [3:0] LCD_IDX_CLOCK_SELECT = 4'h0;
  localparam logic [3:0] LCD_IDX_SUPPLY_CONTROL = 4'h1;
  localparam logic [3:0] LCD_IDX_CONTROL_ONE = 4'h2;
  localparam logic [3:0] LCD_IDX_CONTROL_ZERO = 4'h3;
  localparam logic [3:0] LCD_IDX_BLINK_CONTROL = 4'h4;
  localparam logic [3:0] LCD_IDX_FP_ENABLE_0 = 4'h5;
  localparam int LCD_FP_REGS = 6;

  // reset values
  localparam logic [7:0] LCD_RST_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] LCD_RST_SUPPLY_CONTROL = 8'h00;
  localparam logic [7:0] LCD_RST_CONTROL_ONE = 8'h00;
  localparam logic [7:0] LCD_RST_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] LCD_RST_BLINK_CONTROL = 8'h00;
  localparam logic [7:0] LCD_RST_FP_ENABLE = 8'h00;

  // encodings
  localparam logic [1:0] LCD_SUPPLY_CORE = 2'h1;
  localparam logic [1:0] LCD_DUTY_THIRD = 2'h2;
  localparam logic [1:0] LCD_DUTY_QUARTER = 2'h3;
  localparam logic LCD_SRC_BUS = 1'b1;
  localparam logic LCD_PUMP_TRIPLER = 1'b1;

  // timing: prescale and blink constants
  localparam logic [3:0] LCD_PRESCALE_BY_SIXTEEN_LIMIT = 4'hF;
  localparam int LCD_BLINK_UNIT_FRAMES = 8;
  localparam int LCD_BLINK_CNT_W = 12;

  // register layouts, msb first as stored
  typedef struct packed {
    logic clock_source;
    logic prescale_by_sixteen;
    logic [5:0] clock_adjust_field;
  } lcd_clksel_t;

  typedef struct packed {
    logic charge_pump_enable;
    logic pump_multiplier_select;
    logic high_drive_buffer;
    logic [1:0] pump_clock_adjust;
    logic buffer_bypass;
    logic [1:0] supply_select;
  } lcd_supply_t;

  typedef struct packed {
    logic [5:0] spare;
    logic wait_mode_disable;
    logic deep_low_power_state_mode_disable;
  } lcd_ctrl1_t;

  typedef struct packed {
    logic [1:0] spare;
    logic [2:0] frame_clock_select;
    logic low_power_waveform;
    logic [1:0] duty;
  } lcd_ctrl0_t;

  typedef struct packed {
    logic blink_enable;
    logic [2:0] spare;
    logic blink_mode;
    logic [2:0] blink_rate;
  } lcd_blink_t;

  typedef struct packed {
    lcd_clksel_t clk;
    lcd_supply_t sup;
    lcd_ctrl1_t cr1;
    lcd_ctrl0_t cr0;
    lcd_blink_t blk;
  } lcd_cfg_t;

endpackage

// ===== lcd_tick_div.sv
/*
  lcd_tick_div: counts input ticks and emits one output tick each time
  limit+1 of them have arrived.
  assumes: one clock, synchronous active-low reset, limit held steady.
*/
`timescale 1ns/100ps
module lcd_tick_div #(
  parameter int W = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [W-1:0] i_limit,
  output logic o_tick
);
  logic [W-1:0] cnt_q;
  logic tick_q;

  // a limit lowered below the count wraps on the next terminal compare
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
    end else if (!i_run) begin
      cnt_q <= '0;
    end else if (i_tick) begin
      if (cnt_q >= i_limit) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= i_run && i_tick && (cnt_q >= i_limit);
    end
  end

  assign o_tick = tick_q;
endmodule

// ===== lcd_regs.sv
/*
  lcd_regs: the eleven 8-bit configuration registers and their read port.
  assumes: strobes one cycle long, never both at once; read data valid
  only in the cycle after the read strobe.
*/
`timescale 1ns/100ps
module lcd_regs
  import lcd_pkg::*;
#(
  parameter int NUM_FP = 41
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [LCD_ADDR_W-1:0] i_addr,
  input wire logic [LCD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [LCD_DATA_W-1:0] o_rdata,
  output lcd_cfg_t o_cfg,
  output logic [NUM_FP-1:0] o_fp_en
);
  lcd_cfg_t cfg_q;
  logic [7:0] fp_q [LCD_FP_REGS];
  logic [LCD_FP_REGS*8-1:0] fp_flat;
  logic [LCD_FP_REGS*8-1:0] fp_mask;
  logic [7:0] rdata_q;
  logic [7:0] rd_val;

  assign fp_mask = {LCD_FP_REGS*8{1'b1}} >> (LCD_FP_REGS*8 - NUM_FP);

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cfg_q.clk <= LCD_RST_CLOCK_SELECT;
      cfg_q.sup <= LCD_RST_SUPPLY_CONTROL;
      cfg_q.cr1 <= LCD_RST_CONTROL_ONE;
      cfg_q.cr0 <= LCD_RST_CONTROL_ZERO;
      cfg_q.blk <= LCD_RST_BLINK_CONTROL;
    end else if (i_wr) begin
      case (i_addr)
        LCD_IDX_CLOCK_SELECT: cfg_q.clk <= i_wdata;
        LCD_IDX_SUPPLY_CONTROL: cfg_q.sup <= i_wdata;
        LCD_IDX_CONTROL_ONE: cfg_q.cr1 <= i_wdata;
        LCD_IDX_CONTROL_ZERO: cfg_q.cr0 <= i_wdata;
        LCD_IDX_BLINK_CONTROL: cfg_q.blk <= i_wdata;
        default: ;
      endcase
    end
  end

  // bits beyond the last frontplane pin never store, so they read as zero
  for (genvar g = 0; g < LCD_FP_REGS; g++) begin : g_fp
    always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
        fp_q[g] <= LCD_RST_FP_ENABLE;
      end else if (i_wr && i_addr == LCD_IDX_FP_ENABLE_0 + 4'(g)) begin
        fp_q[g] <= i_wdata & fp_mask[g*8 +: 8];
      end
    end
    assign fp_flat[g*8 +: 8] = fp_q[g];
  end

  always_comb begin
    rd_val = 8'h00;
    case (i_addr)
      LCD_IDX_CLOCK_SELECT: rd_val = cfg_q.clk;
      LCD_IDX_SUPPLY_CONTROL: rd_val = cfg_q.sup;
      LCD_IDX_CONTROL_ONE: rd_val = cfg_q.cr1;
      LCD_IDX_CONTROL_ZERO: rd_val = cfg_q.cr0;
      LCD_IDX_BLINK_CONTROL: rd_val = cfg_q.blk;
      default: begin
        if (i_addr >= LCD_IDX_FP_ENABLE_0 && i_addr < LCD_IDX_FP_ENABLE_0 + 4'(LCD_FP_REGS)) begin
          rd_val = fp_q[3'(i_addr - LCD_IDX_FP_ENABLE_0)];
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_rd ? rd_val : 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_cfg = cfg_q;
  assign o_fp_en = fp_flat[NUM_FP-1:0];
endmodule

// ===== lcd_glass_model.sv
/*
  lcd_glass_model: passive segment glass on the backplane and frontplane
  lines; counts frames and flags backplane patterns the glass cannot take.
  assumes: one clock domain, driver outputs registered on i_clk_sys.
*/
`timescale 1ns/100ps
module lcd_glass_model #(
  parameter int NUM_FP = 41
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [3:0] i_bp_active,
  input wire logic [NUM_FP-1:0] i_fp_drive,
  input wire logic i_wave_polarity,
  output logic [15:0] o_frames,
  output logic o_bad
);
  logic pol_q;
  // two backplanes at once would short the common electrodes
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_bad <= 1'b0;
    end else if (!(i_bp_active inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8})) begin
      o_bad <= 1'b1;
    end
  end
  // one polarity swap per frame keeps the glass free of dc bias
  always_ff @(posedge i_clk_sys) begin
    pol_q <= i_wave_polarity;
    if (!i_reset_n) begin
      o_frames <= 16'h0000;
    end else if (pol_q !== i_wave_polarity) begin
      o_frames <= o_frames + 16'h0001;
    end
  end
endmodule

// ===== lcd_segment_driver_bench.sv
/*
  lcd_segment_driver_bench: directed scenarios for the lcd driver block.
  assumes: bus clock 25 MHz, reset held 5 cycles, blink unit shortened to 1.
*/
`timescale 1ns/100ps
module lcd_segment_driver_bench
  import lcd_pkg::*;
;
  localparam int NFP = 41;
  logic i_clk_sys, i_reset_n, i_wr, i_rd, i_ext_ref, i_wait_mode, i_deep_low_power_state_mode;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rv;
  logic o_clk_from_bus, o_base_tick, o_pump_on, o_pump_triple, o_high_drive;
  logic o_buffer_bypass, o_core_supply, o_bias3_from_core, o_low_power_wave;
  logic o_display_on, o_wave_polarity, o_blink_blank_sel, glass_bad, ext_run;
  logic [1:0] o_pump_clock_adjust;
  logic [3:0] o_bp_active, seen;
  logic [NFP-1:0] o_fp_drive, o_fp_lcd_owned, fp_exp;
  logic [15:0] glass_frames;
  logic [2:0] ext_cnt;
  int failures, total_checks, cyc, n;
  lcd_segment_driver #(.NUM_FP(NFP), .BLINK_UNIT(1)) lcd_segment_driver_i (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_ref(i_ext_ref),
    .i_wait_mode(i_wait_mode), .i_deep_low_power_state_mode(i_deep_low_power_state_mode),
    .o_clk_from_bus(o_clk_from_bus), .o_base_tick(o_base_tick), .o_pump_on(o_pump_on),
    .o_pump_triple(o_pump_triple), .o_high_drive(o_high_drive),
    .o_pump_clock_adjust(o_pump_clock_adjust), .o_buffer_bypass(o_buffer_bypass),
    .o_core_supply(o_core_supply), .o_bias3_from_core(o_bias3_from_core),
    .o_low_power_wave(o_low_power_wave), .o_display_on(o_display_on),
    .o_bp_active(o_bp_active), .o_wave_polarity(o_wave_polarity),
    .o_fp_drive(o_fp_drive), .o_fp_lcd_owned(o_fp_lcd_owned),
    .o_blink_blank_sel(o_blink_blank_sel));
  lcd_glass_model #(.NUM_FP(NFP)) lcd_glass_model_i (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_bp_active(o_bp_active),
    .i_fp_drive(o_fp_drive), .i_wave_polarity(o_wave_polarity),
    .o_frames(glass_frames), .o_bad(glass_bad));

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // slow external reference, one rising edge every 8 bus cycles
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) ext_cnt <= 3'h0;
    else if (ext_run) ext_cnt <= ext_cnt + 3'h1;
    i_ext_ref <= ext_cnt[2];
  end
  // hang guard, well above the roughly 8000 cycles of the scenarios
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_bits(string name, logic [63:0] exp, logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic check_count(string name, int exp, int got);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic settle();
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask
  function automatic logic pick(int s);
    case (s)
      0: return o_base_tick;
      1: return o_bp_active[0];
      default: return o_blink_blank_sel;
    endcase
  endfunction
  // cycles between 2nd and 3rd rise, so a config change never skews it
  task automatic interval(int s, int lim, output int cnt);
    int k, edges;
    logic p;
    cnt = 0;
    edges = 0;
    p = pick(s);
    for (k = 0; k < lim && edges < 3; k++) begin
      @(posedge i_clk_sys);
      #1;
      if (edges == 2) cnt++;
      if (pick(s) === 1'b1 && p !== 1'b1) edges++;
      p = pick(s);
    end
    if (edges < 3) cnt = -1;
  endtask

  task automatic t_reset();
    for (int a = 0; a < 12; a++) begin
      rd(a[3:0], rv);
      check_bits("reset value", 64'h0, rv);
    end
    @(posedge i_clk_sys);
    #1 check_bits("rdata after slot", 64'h0, o_rdata);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 10; a++) begin
      wr(a[3:0], 8'h3C ^ a[7:0]);
      rd(a[3:0], rv);
      check_bits("readback", 8'h3C ^ a[7:0], rv);
    end
    wr(4'hA, 8'hFF);
    rd(4'hA, rv);
    check_bits("frontplane 40 only", 64'h01, rv);
    wr(4'hC, 8'hFF);
    rd(4'hC, rv);
    check_bits("unmapped", 64'h0, rv);
  endtask
  task automatic t_clock();
    wr(LCD_IDX_CONTROL_ONE, 8'h00);
    wr(LCD_IDX_CLOCK_SELECT, 8'h82);
    settle();
    check_bits("bus source", 64'h1, o_clk_from_bus);
    interval(0, 100, n);
    check_count("base period adj2", 3, n);
    wr(LCD_IDX_CLOCK_SELECT, 8'hC2);
    interval(0, 400, n);
    check_count("base period prescale_by_sixteen", 48, n);
    ext_run <= 1'b1;
    wr(LCD_IDX_CLOCK_SELECT, 8'h00);
    interval(0, 100, n);
    check_count("base period ext", 8, n);
    check_bits("ext source", 64'h0, o_clk_from_bus);
  endtask
  task automatic t_supply();
    logic [7:0] wv[3] = '{8'hC4, 8'hE9, 8'h12};
    logic [7:0] ev[3] = '{8'hC4, 8'hAB, 8'h10};
    for (int k = 0; k < 3; k++) begin
      wr(LCD_IDX_SUPPLY_CONTROL, wv[k]);
      settle();
      check_bits("supply outputs", ev[k], {o_pump_on, o_pump_triple, o_high_drive,
        o_pump_clock_adjust, o_buffer_bypass, o_core_supply,
        o_bias3_from_core});
    end
  endtask
  task automatic t_frame(logic [7:0] cr0, int per, logic [3:0] bps);
    wr(LCD_IDX_CLOCK_SELECT, 8'h82);
    wr(LCD_IDX_CONTROL_ZERO, cr0);
    interval(1, 600, n);
    check_count("frame period", per, n);
    check_bits("low power wave", cr0[2], o_low_power_wave);
    seen = 4'h0;
    repeat (per) begin
      @(posedge i_clk_sys);
      #1 seen = seen | o_bp_active;
    end
    check_bits("backplanes used", bps, seen);
  endtask
  task automatic t_fp();
    logic [7:0] fpv[6] = '{8'hA5, 8'h5A, 8'hFF, 8'h00, 8'h3C, 8'hFF};
    for (int k = 0; k < 6; k++) wr(LCD_IDX_FP_ENABLE_0 + k[3:0], fpv[k]);
    for (int b = 0; b < NFP; b++) fp_exp[b] = fpv[b / 8][b % 8];
    settle();
    check_bits("lcd owned", fp_exp, o_fp_lcd_owned);
    check_bits("fp drive", fp_exp, o_fp_drive);
    wr(LCD_IDX_FP_ENABLE_0, 8'h00);
    settle();
    fp_exp[7:0] = 8'h00;
    check_bits("released owned", fp_exp, o_fp_lcd_owned);
    check_bits("released drive", fp_exp, o_fp_drive);
  endtask
  task automatic t_power();
    wr(LCD_IDX_CONTROL_ONE, 8'h01);
    i_wait_mode <= 1'b1;
    settle();
    check_bits("on in wait", 64'h1, o_display_on);
    i_wait_mode <= 1'b0;
    i_deep_low_power_state_mode <= 1'b1;
    settle();
    check_bits("off in deep_low_power_state", 64'h0, {o_display_on, o_bp_active, o_fp_drive});
    i_deep_low_power_state_mode <= 1'b0;
    settle();
    check_bits("on after deep_low_power_state", 64'h1, o_display_on);
    wr(LCD_IDX_CONTROL_ONE, 8'h02);
    i_wait_mode <= 1'b1;
    settle();
    check_bits("off in wait", 64'h0, {o_display_on, o_bp_active});
    i_wait_mode <= 1'b0;
    i_deep_low_power_state_mode <= 1'b1;
    settle();
    check_bits("on in deep_low_power_state", 64'h1, o_display_on);
    i_deep_low_power_state_mode <= 1'b0;
  endtask
  task automatic t_blink();
    wr(LCD_IDX_BLINK_CONTROL, 8'h84);
    interval(2, 8000, n);
    check_count("blink period", 2 * 16 * 72, n);
    check_bits("individual drives", 64'h1, o_fp_drive !== '0);
    wr(LCD_IDX_BLINK_CONTROL, 8'h88);
    seen = 4'h0;
    repeat (300) begin
      @(posedge i_clk_sys);
      #1 if (o_fp_drive === '0) seen[0] = 1'b1;
      if (o_blink_blank_sel !== 1'b0) seen[1] = 1'b1;
    end
    check_bits("all blanked", 64'h1, seen);
  endtask

  initial begin
    {i_wr, i_rd, i_wait_mode, i_deep_low_power_state_mode, ext_run} = '0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    failures = 0;
    total_checks = 0;
    i_reset_n = 1'b0;
    repeat (5) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_clock();
    t_supply();
    t_frame(8'h1B, 96, 4'hF);
    t_frame(8'h1D, 48, 4'h3);
    t_frame(8'h1A, 72, 4'h7);
    t_fp();
    t_power();
    t_blink();
    check_bits("glass pattern", 64'h0, glass_bad);
    check_bits("glass frames", 64'h1, glass_frames != 16'h0);
    complete_run();
  end
endmodule
